// ==== rtl/mtim_pkg.sv ====
// Shared constants, bus carriers and enumerations for the modulo overflow timer
package mtim_pkg;

  // Bus widths
  localparam int unsigned APB_ADDR_W   = 12;
  localparam int unsigned APB_DATA_W   = 32;

  // Register byte offsets
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] CLOCK_OFFSET  = 12'h004;
  localparam logic [11:0] COUNT_OFFSET  = 12'h008;
  localparam logic [11:0] LIMIT_OFFSET  = 12'h00c;
  localparam logic [11:0] MODE_OFFSET   = 12'h010;

  // timer_status_control field positions
  localparam int unsigned FLAG_BIT      = 7;
  localparam int unsigned IRQ_EN_BIT    = 6;
  localparam int unsigned CLEAR_BIT     = 5;
  localparam int unsigned HALT_BIT      = 4;

  // timer_clock_config field positions
  localparam int unsigned SRC_LSB       = 4;
  localparam int unsigned DIV_LSB       = 0;

  // Largest prescale code; higher codes fold onto it
  localparam logic [3:0]  DIV_MAX       = 4'h8;

  // Reset values
  localparam logic        HALT_RESET    = 1'b1;
  localparam logic        IRQ_EN_RESET  = 1'b0;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  LIMIT_RESET   = 8'h00;
  localparam logic [1:0]  SRC_RESET     = 2'h0;
  localparam logic [3:0]  DIV_RESET     = 4'h0;

  // Count source encodings
  typedef enum logic [1:0] {
    src_bus      = 2'h0,
    src_fixed    = 2'h1,
    src_ext_fall = 2'h2,
    src_ext_rise = 2'h3
  } count_source_t;

  // Counter modes, Gray coded along stopped, free, wrapping
  typedef enum logic [1:0] {
    mode_stopped = 2'h0,
    mode_free    = 2'h1,
    mode_wrap    = 2'h3
  } count_mode_t;

  // APB request from the master
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  // APB answer from this slave
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// ==== rtl/modulo_overflow_timer.sv ====
// Modulo overflow timer with prescaler, selectable count source and APB registers
// Operation
// - Count register is read-only, writes ignored, cleared to zero by reset.
// - Limit zero while running means free count over the whole range.
// - Any limit write zeroes the count and clears the wrap flag.
// - Three modes: stopped, free, wrapping; reset leaves it stopped.
// - Nonzero limit while running means wrapping mode.
// - Reset picks bus clock, divide-by-1, count and limit zero.
// - Writing status with halt cleared starts counting, free if limit zero.
// - Four sources: bus clock, fixed clock, pin falling or rising edges.
// - Changing source while active keeps the count and continues.
// - Prescaler divides by 1, 2, 4 up to 256 by divider code.
// - Changing divider while active keeps the count and continues.
// - Divider code 0010 gives divide-by-4.
// - Any limit from 01 to ff is a valid wrap point.
// - Count increments per tick until equal to limit, then wraps to zero.
// - Wrap flag sets exactly on the limit-to-zero transition, or the ff-to-zero one with limit zero.
// - A zero write clears the flag only after a status read with flag set.
// - A wrap between that read and write cancels the clear.
// - Writing one to the clear strobe also clears the wrap flag.
// - Interrupt request asserts while flag and interrupt enable are both set.
// - Halt freezes the count, clearing it resumes; reset sets halt.
// - Clear strobe zeroes the count and always reads as zero.
// - Source codes: 00 bus, 01 fixed, 10 pin falling, 11 pin rising.
// - Divider codes ascend in powers of two; codes above eight give 256.
`timescale 1ns/1ps
`default_nettype none

module modulo_overflow_timer #(
  parameter int unsigned COUNT_W    = 8,
  parameter int unsigned PRESCALE_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire mtim_pkg::apb_req_t apb_req,
  output var  mtim_pkg::apb_rsp_t apb_rsp,
  input  wire logic              fixed_rate_clock,
  input  wire logic              external_count_pin,
  output var  logic              wrap_irq
);

  // Register map: one 32-bit word each, data in bits 7:0
  //   000 timer_status_control
  //       7   wrap_flag, read; writing 0 clears once armed
  //       6   wrap_irq_enable, read/write
  //       5   count_clear_strobe, write 1 only, reads 0
  //       4   count_halt, read/write, set by reset
  //       3:0 read as zero
  //   004 timer_clock_config
  //       5:4 source_select
  //       3:0 divider_select
  //   008 event_count_value, read only
  //   00c wrap_limit, read/write
  //   010 counter mode, read only
  //       00 stopped, 01 free running, 11 wrapping
  //   Any other address answers with pslverr
  // Counting
  //   Pins pass three flops; stages two and three must agree
  //   Source ticks feed the prescaler only while running
  //   Prescale tick when its low n bits are all ones, ratio 2^n
  //   Divider codes above eight give divide-by-256
  //   Count wraps to zero at the limit, or at ff with limit zero
  //   Limit write and clear strobe zero count, flag and prescaler
  //   A wrap in the same cycle as a clear keeps the flag set
  // Timing
  //   Zero wait states: pready follows setup by one cycle
  //   Writes land on the completing access edge
  //   Pin edges reach the counter three to four cycles late
  //   Halt changes land with the write; mode shows one cycle after it
  //   Arming needs the returned flag, not the live one
  //   The interrupt lags flag and enable by one cycle

  // Outside inputs, fixed clock at index 0 and count pin at index 1
  logic [1:0]                pin_in;
  logic [1:0]                sync1_reg;
  logic [1:0]                sync2_reg;
  logic [1:0]                sync3_reg;
  logic [1:0]                level_reg;
  logic [1:0]                rise_pulse;
  logic [1:0]                fall_pulse;

  // Register state
  logic                      wrap_flag_reg;
  logic                      wrap_irq_enable_reg;
  logic                      count_halt_reg;
  logic                      clear_armed_reg;
  mtim_pkg::count_source_t   source_select_reg;
  logic [3:0]                divider_select_reg;
  logic [COUNT_W-1:0]        event_count_value_reg;
  logic [COUNT_W-1:0]        wrap_limit_reg;
  mtim_pkg::count_mode_t     mode_reg;
  mtim_pkg::count_mode_t     mode_next;
  logic [PRESCALE_W-1:0]     prescale_reg;

  // Bus decode and strobes
  logic                      setup_phase;
  logic                      access_done;
  logic                      write_done;
  logic                      sel_status;
  logic                      sel_clock;
  logic                      sel_count;
  logic                      sel_limit;
  logic                      sel_mode;
  logic                      addr_ok;
  logic [31:0]               read_next;
  logic                      status_write;
  logic                      clock_write;
  logic                      limit_write;
  logic                      status_read_done;
  logic                      clear_strobe;
  logic                      clear_event;
  logic                      flag_clear;

  // Counting path
  logic                      running;
  logic                      source_tick;
  logic [3:0]                ratio_code;
  logic [PRESCALE_W-1:0]     ratio_mask;
  logic                      prescale_tick;
  logic                      at_wrap_point;
  logic                      wrap_event;

  // Mask with the low n bits set
  function automatic logic [PRESCALE_W-1:0] low_mask(input logic [3:0] n);
    logic [PRESCALE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRESCALE_W; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

  assign pin_in = {external_count_pin, fixed_rate_clock};

  // Only stage two reads stage one, to contain metastability
  // Three-stage synchroniser and filtered edge detect per input
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        sync3_reg[g] <= 1'b0;
        level_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= pin_in[g];
        sync2_reg[g] <= sync1_reg[g];
        sync3_reg[g] <= sync2_reg[g];
        if (sync2_reg[g] == sync3_reg[g]) begin
          level_reg[g] <= sync3_reg[g];
        end
      end
    end

    // One-cycle enables once stages two and three agree
    assign rise_pulse[g] = (sync2_reg[g] == sync3_reg[g]) && sync3_reg[g] && !level_reg[g];
    assign fall_pulse[g] = (sync2_reg[g] == sync3_reg[g]) && !sync3_reg[g] && level_reg[g];
  end

  // Count source selection, no state touched on change
  always_comb begin
    case (source_select_reg)
      mtim_pkg::src_bus:      source_tick = 1'b1;
      mtim_pkg::src_fixed:    source_tick = rise_pulse[0];
      mtim_pkg::src_ext_fall: source_tick = fall_pulse[1];
      mtim_pkg::src_ext_rise: source_tick = rise_pulse[1];
      default:                source_tick = 1'b1;
    endcase
  end

  // Folding keeps the mask inside the prescaler width
  // Prescale ratio 2^code, codes above the top fold onto 256
  assign ratio_code    = (divider_select_reg > mtim_pkg::DIV_MAX) ? mtim_pkg::DIV_MAX : divider_select_reg;
  assign ratio_mask    = low_mask(ratio_code);
  assign prescale_tick = source_tick && ((prescale_reg & ratio_mask) == ratio_mask);

  // A free-running wrap from ff also sets the flag
  // Wrap point: limit match, or all ones when free running
  assign running       = !count_halt_reg;
  assign at_wrap_point = (wrap_limit_reg != '0) ? (event_count_value_reg == wrap_limit_reg)
                                                : (event_count_value_reg == {COUNT_W{1'b1}});
  assign wrap_event    = running && prescale_tick && at_wrap_point;

  // APB phase detection
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign write_done  = access_done && apb_req.pwrite && apb_req.pstrb[0] && !apb_rsp.pslverr;

  // Exact word match; misaligned addresses are unmapped
  // Address decode
  always_comb begin
    sel_status = 1'b0;
    sel_clock  = 1'b0;
    sel_count  = 1'b0;
    sel_limit  = 1'b0;
    sel_mode   = 1'b0;
    if (apb_req.paddr == mtim_pkg::STATUS_OFFSET) begin
      sel_status = 1'b1;
    end else if (apb_req.paddr == mtim_pkg::CLOCK_OFFSET) begin
      sel_clock = 1'b1;
    end else if (apb_req.paddr == mtim_pkg::COUNT_OFFSET) begin
      sel_count = 1'b1;
    end else if (apb_req.paddr == mtim_pkg::LIMIT_OFFSET) begin
      sel_limit = 1'b1;
    end else if (apb_req.paddr == mtim_pkg::MODE_OFFSET) begin
      sel_mode = 1'b1;
    end
  end

  assign addr_ok = sel_status || sel_clock || sel_count || sel_limit || sel_mode;

  // Read data mux, unused bits read zero
  always_comb begin
    read_next = '0;
    if (sel_status) begin
      read_next[mtim_pkg::FLAG_BIT]   = wrap_flag_reg;
      read_next[mtim_pkg::IRQ_EN_BIT] = wrap_irq_enable_reg;
      read_next[mtim_pkg::CLEAR_BIT]  = 1'b0;
      read_next[mtim_pkg::HALT_BIT]   = count_halt_reg;
    end else if (sel_clock) begin
      read_next[mtim_pkg::SRC_LSB +: 2] = source_select_reg;
      read_next[mtim_pkg::DIV_LSB +: 4] = divider_select_reg;
    end else if (sel_count) begin
      read_next[COUNT_W-1:0] = event_count_value_reg;
    end else if (sel_limit) begin
      read_next[COUNT_W-1:0] = wrap_limit_reg;
    end else if (sel_mode) begin
      read_next[1:0] = mode_reg;
    end
  end

  // Writes need pstrb bit zero; count and mode writes fall away
  // Write and read completion strobes
  assign status_write     = write_done && sel_status;
  assign clock_write      = write_done && sel_clock;
  assign limit_write      = write_done && sel_limit; // count writes fall through
  assign status_read_done = access_done && !apb_req.pwrite && sel_status;
  assign clear_strobe     = status_write && apb_req.pwdata[mtim_pkg::CLEAR_BIT];
  assign clear_event      = limit_write || clear_strobe;
  assign flag_clear       = clear_event
                          || (status_write && !apb_req.pwdata[mtim_pkg::FLAG_BIT] && clear_armed_reg);

  // Read data is captured at setup and held until the next setup
  // Bus answer: one wait-free access phase, error on unmapped address
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      apb_rsp <= '0;
    end else if (setup_phase) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= !addr_ok;
      apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : read_next;
    end else begin
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

  // Status control bits
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_halt_reg      <= mtim_pkg::HALT_RESET;
      wrap_irq_enable_reg <= mtim_pkg::IRQ_EN_RESET;
    end else if (status_write) begin
      count_halt_reg      <= apb_req.pwdata[mtim_pkg::HALT_BIT];
      wrap_irq_enable_reg <= apb_req.pwdata[mtim_pkg::IRQ_EN_BIT];
    end
  end

  // Clock configuration
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      source_select_reg  <= mtim_pkg::count_source_t'(mtim_pkg::SRC_RESET);
      divider_select_reg <= mtim_pkg::DIV_RESET;
    end else if (clock_write) begin
      source_select_reg  <= mtim_pkg::count_source_t'(apb_req.pwdata[mtim_pkg::SRC_LSB +: 2]);
      divider_select_reg <= apb_req.pwdata[mtim_pkg::DIV_LSB +: 4];
    end
  end

  // Wrap limit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrap_limit_reg <= COUNT_W'(mtim_pkg::LIMIT_RESET);
    end else if (limit_write) begin
      wrap_limit_reg <= apb_req.pwdata[COUNT_W-1:0];
    end
  end

  // Prescaler advances only while running, restarts with the count
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prescale_reg <= '0;
    end else if (clear_event) begin
      prescale_reg <= '0;
    end else if (running && source_tick) begin
      prescale_reg <= prescale_reg + PRESCALE_W'(1);
    end
  end

  // Main counter
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      event_count_value_reg <= COUNT_W'(mtim_pkg::COUNT_RESET);
    end else if (clear_event) begin
      event_count_value_reg <= '0;
    end else if (running && prescale_tick) begin
      if (wrap_event) begin
        event_count_value_reg <= '0;
      end else begin
        event_count_value_reg <= event_count_value_reg + COUNT_W'(1);
      end
    end
  end

  // Losing a wrap is worse than repeating a clear
  // Wrap flag, a wrap in the same cycle beats any clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrap_flag_reg <= 1'b0;
    end else if (wrap_event) begin
      wrap_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      wrap_flag_reg <= 1'b0;
    end
  end

  // Any status write disarms, so a stale read cannot clear a later wrap
  // Clear arming: status read that returned the flag set
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clear_armed_reg <= 1'b0;
    end else if (wrap_event) begin
      clear_armed_reg <= 1'b0;
    end else if (status_write) begin
      clear_armed_reg <= 1'b0;
    end else if (status_read_done && apb_rsp.prdata[mtim_pkg::FLAG_BIT]) begin
      clear_armed_reg <= 1'b1;
    end
  end

  // Mode tracking
  always_comb begin
    if (count_halt_reg) begin
      mode_next = mtim_pkg::mode_stopped;
    end else if (wrap_limit_reg == '0) begin
      mode_next = mtim_pkg::mode_free;
    end else begin
      mode_next = mtim_pkg::mode_wrap;
    end
  end

  // Registered mode, read back at the mode offset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_reg <= mtim_pkg::mode_stopped;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Lags flag and enable by one cycle; no other source
  // Interrupt request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrap_irq <= 1'b0;
    end else begin
      wrap_irq <= wrap_flag_reg && wrap_irq_enable_reg;
    end
  end

endmodule

`default_nettype wire

// ==== verification/modulo_overflow_timer_assertions.sv ====
// Port-level checks for the modulo overflow timer
`timescale 1ns/1ps
`default_nettype none
module modulo_overflow_timer_assertions #(
  parameter int unsigned COUNT_W    = 8,
  parameter int unsigned PRESCALE_W = 8
) (
  input wire logic               mclk,
  input wire logic               reset,
  input wire mtim_pkg::apb_req_t apb_req,
  input wire mtim_pkg::apb_rsp_t apb_rsp,
  input wire logic               fixed_rate_clock,
  input wire logic               external_count_pin,
  input wire logic               wrap_irq
);
  logic       wr_done;
  logic       rd_done;
  logic [7:0] limit_q;
  logic [5:0] clk_q;
  logic       en_q;
  logic       halt_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Completed transfers at the access edge
  assign wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.pstrb[0];
  assign rd_done = apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite;
  // Shadow copies of the writable fields
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      limit_q <= 8'h00;
      clk_q   <= 6'h00;
      en_q    <= 1'b0;
      halt_q  <= 1'b1;
    end else if (wr_done) begin
      if (apb_req.paddr == mtim_pkg::LIMIT_OFFSET) limit_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == mtim_pkg::CLOCK_OFFSET) clk_q <= apb_req.pwdata[5:0];
      if (apb_req.paddr == mtim_pkg::STATUS_OFFSET) en_q <= apb_req.pwdata[6];
      if (apb_req.paddr == mtim_pkg::STATUS_OFFSET) halt_q <= apb_req.pwdata[4];
    end
  end
  // Bus handshake steps
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence answer_s;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  a_ready_one_shot: assert property (setup_s |=> answer_s)
    else $error("pready did not pulse once after setup");
  a_unmapped_error: assert property (setup_s and !(apb_req.paddr inside {12'h000, 12'h004, 12'h008, 12'h00c,
    12'h010}) |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
  a_status_fields: assert property (rd_done && apb_req.paddr == mtim_pkg::STATUS_OFFSET |->
    apb_rsp.prdata[31:8] == 24'h0 && apb_rsp.prdata[5:0] == {1'b0, $past(halt_q), 4'h0}
    && apb_rsp.prdata[6] == $past(en_q)) else $error("status read wrong");
  a_mode_code: assert property (rd_done && apb_req.paddr == mtim_pkg::MODE_OFFSET |->
    apb_rsp.prdata == ($past(halt_q, 2) ? 32'h0 : ($past(limit_q, 2) != 8'h00 ? 32'h3 : 32'h1)))
    else $error("mode does not match halt and limit");
  a_clock_cfg: assert property (rd_done && apb_req.paddr == mtim_pkg::CLOCK_OFFSET |->
    apb_rsp.prdata == {26'h0, $past(clk_q)}) else $error("clock config read wrong");
  a_limit_read: assert property (rd_done && apb_req.paddr == mtim_pkg::LIMIT_OFFSET |->
    apb_rsp.prdata == {24'h0, $past(limit_q)}) else $error("limit read wrong");
  a_count_bound: assert property (rd_done && apb_req.paddr == mtim_pkg::COUNT_OFFSET |->
    apb_rsp.prdata[31:8] == 24'h0 && ($past(limit_q) == 8'h00 || apb_rsp.prdata[7:0] <= $past(limit_q)))
    else $error("count above limit");
  a_irq_needs_en: assert property (!$past(en_q) |-> !wrap_irq)
    else $error("interrupt without enable");
  a_limit_clears: assert property (wr_done && apb_req.paddr == mtim_pkg::LIMIT_OFFSET && en_q ##1 1'b1
    |=> !wrap_irq) else $error("interrupt after limit write");
endmodule
`default_nettype wire

// ==== verification/modulo_overflow_timer_bench.sv ====
// Register-level bench for the modulo overflow timer
`timescale 1ns/1ps
`default_nettype none
module modulo_overflow_timer_bench;
  localparam logic [11:0] ST = mtim_pkg::STATUS_OFFSET;
  localparam logic [11:0] CK = mtim_pkg::CLOCK_OFFSET;
  localparam logic [11:0] CN = mtim_pkg::COUNT_OFFSET;
  localparam logic [11:0] LM = mtim_pkg::LIMIT_OFFSET;
  localparam logic [11:0] MD = mtim_pkg::MODE_OFFSET;
  logic               mclk;
  logic               reset;
  mtim_pkg::apb_req_t apb_req;
  mtim_pkg::apb_rsp_t apb_rsp;
  logic               tick;
  logic               use_fixed;
  wire logic          fixed_rate_clock;
  wire logic          external_count_pin;
  logic               wrap_irq;
  logic [31:0]        rd;
  logic               err;
  int                 n_mismatch;
  int                 checks_done;
  // One stimulus line steers either count input
  assign fixed_rate_clock   = use_fixed & tick;
  assign external_count_pin = ~use_fixed & tick;
  modulo_overflow_timer #(.COUNT_W(8), .PRESCALE_W(8)) dut (.mclk(mclk), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .fixed_rate_clock(fixed_rate_clock), .external_count_pin(external_count_pin),
    .wrap_irq(wrap_irq));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic xfer(input logic [11:0] addr, input logic wr, input logic [31:0] data);
    @(posedge mclk);
    apb_req.paddr  <= addr;
    apb_req.pwrite <= wr;
    apb_req.pwdata <= data;
    apb_req.psel   <= 1'b1;
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    @(posedge mclk);
    while (apb_rsp.pready !== 1'b1) @(posedge mclk);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] addr, input logic [31:0] exp);
    xfer(addr, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Count edges, then allow for synchroniser latency
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick <= 1'b1;
      repeat (4) @(posedge mclk);
      tick <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    apb_req = '0;
    apb_req.pstrb = 4'hf;
    tick = 1'b0;
    use_fixed = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rchk(ST, 32'h10);
    rchk(CK, 32'h00);
    rchk(LM, 32'h00);
    rchk(MD, 32'h00);
    xfer(CN, 1'b1, 32'h55);
    rchk(CN, 32'h00);
    xfer(12'h014, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(ST, 1'b1, 32'h00);
    rchk(MD, 32'h01);
    xfer(ST, 1'b1, 32'h10);
    xfer(CK, 1'b1, 32'h30);
    xfer(LM, 1'b1, 32'h03);
    rchk(CN, 32'h00);
    xfer(ST, 1'b1, 32'h00);
    rchk(MD, 32'h03);
    pulse(3);
    rchk(CN, 32'h03);
    rchk(ST, 32'h00);
    pulse(1);
    rchk(CN, 32'h00);
    rchk(ST, 32'h80);
    pulse(1);
    xfer(ST, 1'b1, 32'h00);
    rchk(ST, 32'h00);
    pulse(3);
    rchk(ST, 32'h80);
    pulse(4);
    xfer(ST, 1'b1, 32'h00);
    rchk(ST, 32'h80);
    xfer(ST, 1'b1, 32'h80);
    xfer(ST, 1'b1, 32'h00);
    rchk(ST, 32'h80);
    xfer(ST, 1'b1, 32'h00);
    rchk(ST, 32'h00);
    xfer(ST, 1'b1, 32'h40);
    rchk(ST, 32'h40);
    chk({31'h0, wrap_irq}, 32'h0);
    pulse(4);
    chk({31'h0, wrap_irq}, 32'h1);
    rchk(ST, 32'hc0);
    pulse(1);
    xfer(ST, 1'b1, 32'he0);
    rchk(ST, 32'h40);
    rchk(CN, 32'h00);
    chk({31'h0, wrap_irq}, 32'h0);
    pulse(4);
    rchk(ST, 32'hc0);
    xfer(LM, 1'b1, 32'hff);
    rchk(ST, 32'h40);
    rchk(LM, 32'hff);
    pulse(2);
    xfer(ST, 1'b1, 32'h50);
    pulse(2);
    rchk(CN, 32'h02);
    xfer(ST, 1'b1, 32'h40);
    pulse(1);
    rchk(CN, 32'h03);
    xfer(CK, 1'b1, 32'h20);
    pulse(2);
    rchk(CN, 32'h05);
    use_fixed <= 1'b1;
    xfer(CK, 1'b1, 32'h10);
    pulse(2);
    rchk(CN, 32'h07);
    use_fixed <= 1'b0;
    for (int d = 1; d < 4; d++) begin
      xfer(CK, 1'b1, 32'h30 | d);
      xfer(ST, 1'b1, 32'h60);
      pulse(8);
      rchk(CN, 32'h8 >> d);
    end
    xfer(CK, 1'b1, 32'h30);
    pulse(2);
    rchk(CN, 32'h03);
    xfer(CK, 1'b1, 32'h0c);
    xfer(ST, 1'b1, 32'h60);
    repeat (300) @(posedge mclk);
    rchk(CN, 32'h01);
    stop_test();
  end
endmodule
bind modulo_overflow_timer modulo_overflow_timer_assertions #(.COUNT_W(COUNT_W), .PRESCALE_W(PRESCALE_W)) chk_i (
  .mclk(mclk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .fixed_rate_clock(fixed_rate_clock),
  .external_count_pin(external_count_pin), .wrap_irq(wrap_irq));
`default_nettype wire
